// ---- rtl/camctl_pkg.sv ----
// Shared constants, types and helpers of the camera viewer control block
package camctl_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS      = 10;
	localparam int DEBOUNCE_NS        = 5_000_000;
	localparam int DEBOUNCE_CYCLES    = DEBOUNCE_NS / CLK_PERIOD_NS;
	localparam int EXP_TICK_NS        = 1_000_000;
	localparam int EXP_TICK_CYCLES    = EXP_TICK_NS / CLK_PERIOD_NS;
	localparam int SENSOR_RST_NS      = 1_000;
	localparam int SENSOR_RST_CYCLES  = (SENSOR_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_EXPOSURE  = 8'h08;
	localparam logic [7:0] REG_FRAME_CNT = 8'h0C;

	// Control register fields (write one to act)
	localparam int CTRL_CAPTURE_BIT = 0;
	localparam int CTRL_LIVE_BIT    = 1;
	localparam int CTRL_RESET_BIT   = 2;

	// Status register fields
	localparam int STAT_STATE_LSB   = 0;
	localparam int STAT_SRST_BIT    = 4;
	localparam int STAT_MIRROR_BIT  = 5;
	localparam int STAT_DIR_BIT     = 6;

	// Reset values and limits
	localparam logic [15:0] EXPOSURE_RST    = 16'h0400;
	localparam logic [15:0] EXPOSURE_MIN    = 16'h0001;
	localparam logic [15:0] EXPOSURE_MAX    = 16'hFFFF;
	localparam logic [15:0] EXP_STEP_RST    = 16'h0001;
	localparam logic [15:0] EXP_STEP_MAX    = 16'h0100;
	localparam logic        MIRROR_RST      = 1'b1;
	localparam logic [31:0] FRAME_CNT_RST   = 32'h0000_0000;

	// AXI4-Lite responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [3:0] {
		ST_WAIT_CFG = 4'b0001,
		ST_LIVE     = 4'b0010,
		ST_CAPTURE  = 4'b0100,
		ST_STILL    = 4'b1000
	} camctl_state_e;

	// Per-button flags: one-cycle press events, or debounced held levels
	typedef struct packed {
		logic live;
		logic capture;
		logic exposure;
		logic circuit_reset;
	} camctl_keys_s;

	// Seven-segment pattern, segment a in bit 0, lit when low
	function automatic logic [6:0] camctl_seg(input logic [3:0] nib);
		logic [6:0] s;
		s = 7'h7F;
		case (nib)
			4'h0: s = 7'h40;
			4'h1: s = 7'h79;
			4'h2: s = 7'h24;
			4'h3: s = 7'h30;
			4'h4: s = 7'h19;
			4'h5: s = 7'h12;
			4'h6: s = 7'h02;
			4'h7: s = 7'h78;
			4'h8: s = 7'h00;
			4'h9: s = 7'h10;
			4'hA: s = 7'h08;
			4'hB: s = 7'h03;
			4'hC: s = 7'h46;
			4'hD: s = 7'h21;
			4'hE: s = 7'h06;
			4'hF: s = 7'h0E;
			default: s = 7'h7F;
		endcase
		return s;
	endfunction : camctl_seg

endpackage : camctl_pkg

// ---- rtl/camctl_debounce.sv ----
// Push-button synchroniser and debouncer with press pulse
`timescale 1ns/1ps
module camctl_debounce
	import camctl_pkg::*;
#(
	parameter int STABLE_CYCLES = DEBOUNCE_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Button pin, low when pressed
	input  wire logic key_n,
	// Debounced results
	output logic      held_ff,
	output logic      press_ff
);
	logic        sync1_ff;
	logic        sync2_ff;
	logic [23:0] cnt_ff;
	logic        pressed;
	logic        differs;
	logic        settled;

	assign pressed = ~sync2_ff;
	assign differs = pressed != held_ff;
	assign settled = differs && (cnt_ff == 24'(STABLE_CYCLES - 1));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
		end else begin
			sync1_ff <= key_n;
			sync2_ff <= sync1_ff;
		end
	end

	// Level must hold a full interval before it counts
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff   <= 24'h00_0000;
			held_ff  <= 1'b0;
			press_ff <= 1'b0;
		end else begin
			cnt_ff   <= (differs && !settled) ? cnt_ff + 24'h00_0001 : 24'h00_0000;
			held_ff  <= settled ? pressed : held_ff;
			press_ff <= settled && pressed;
		end
	end

endmodule : camctl_debounce

// ---- rtl/camctl_top.sv ----
// Camera viewer control: modes, exposure, mirror setup, frame counter, registers
//
// Function
// - Once sensor configuration finishes, enter live view with no user action.
// - Reset button returns whole control circuit to start, including live view.
// - Capture button takes one shot and freezes the displayed frame.
// - Live button during a held still resumes continuous display.
// - Holding exposure button keeps changing exposure, change grows with hold time.
// - Direction switch off lengthens exposure, on shortens it.
// - Mirror switch selects line mirroring, taken only at the next circuit reset.
// - Sensor configuration enables left-right mirroring by default.
// - Running frame count shown on eight seven-segment digits, display only.
`timescale 1ns/1ps
module camctl_top
	import camctl_pkg::*;
#(
	parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
	parameter int TICK_CYCLES = EXP_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Buttons (low when pressed): 0 reset, 1 exposure, 2 capture, 3 live
	input  wire logic [3:0]  key_n,
	// Slide switches
	input  wire logic        exposure_direction_switch,
	input  wire logic        line_mirror_switch,
	// Sensor path
	input  wire logic        frame_start,
	input  wire logic        config_done,
	output logic             sensor_rst_n_ff,
	output logic             mirror_cfg_ff,
	output logic [15:0]      exposure_ff,
	output logic             freeze_ff,
	// Display
	output logic [7:0][6:0]  hex_seg_n_ff,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	camctl_keys_s  key_press;
	camctl_keys_s  key_held;
	camctl_state_e state_ff;
	camctl_state_e nxt_state;

	logic [2:0]  fs_sync_ff;
	logic [1:0]  dir_sync_ff;
	logic [1:0]  mir_sync_ff;
	logic [7:0]  srst_cnt_ff;
	logic [31:0] frame_cnt_ff;
	logic [23:0] tick_cnt_ff;
	logic [15:0] step_ff;
	logic        frame_edge;
	logic        circ_rst;
	logic        srst_done;
	logic        tick;
	logic        exp_up_sat;
	logic        exp_dn_sat;
	logic [15:0] nxt_exposure;

	// Each button through its own debouncer
	genvar gk;
	generate
		for (gk = 0; gk < 4; gk++) begin : g_key
			camctl_debounce #(
				.STABLE_CYCLES(DEB_CYCLES)
			) u_deb (
				.clk     (clk),
				.nrst    (nrst),
				.key_n   (key_n[gk]),
				.held_ff (key_held[gk]),
				.press_ff(key_press[gk])
			);
		end
	endgenerate
	// lines up: bit 0 reset, 1 exposure, 2 capture, 3 live

	// Pin synchronisers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fs_sync_ff  <= 3'h0;
			dir_sync_ff <= 2'h0;
			mir_sync_ff <= 2'h0;
		end else begin
			fs_sync_ff  <= {fs_sync_ff[1:0], frame_start};
			dir_sync_ff <= {dir_sync_ff[0], exposure_direction_switch};
			mir_sync_ff <= {mir_sync_ff[0], line_mirror_switch};
		end
	end
	assign frame_edge = fs_sync_ff[1] && !fs_sync_ff[2];

	// AXI4-Lite write path
	logic [7:0]  wr_addr_q;
	logic        wr_fire;
	logic        wr_ctrl;
	logic        wr_exp;
	logic        wr_hit;
	logic        sw_capture;
	logic        sw_live;
	logic        sw_reset;

	assign wr_fire    = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign wr_addr_q  = {s_axi_awaddr[7:2], 2'b00};
	assign wr_ctrl    = wr_fire && (wr_addr_q == REG_CTRL);
	assign wr_exp     = wr_fire && (wr_addr_q == REG_EXPOSURE);
	assign wr_hit     = (wr_addr_q == REG_CTRL) || (wr_addr_q == REG_EXPOSURE);
	assign sw_capture = wr_ctrl && s_axi_wstrb[0] && s_axi_wdata[CTRL_CAPTURE_BIT];
	assign sw_live    = wr_ctrl && s_axi_wstrb[0] && s_axi_wdata[CTRL_LIVE_BIT];
	assign sw_reset   = wr_ctrl && s_axi_wstrb[0] && s_axi_wdata[CTRL_RESET_BIT];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read path
	logic [7:0]  rd_addr_q;
	logic        rd_fire;
	logic        rd_hit;
	logic [31:0] rd_status;
	logic [31:0] rd_data;

	assign rd_fire   = s_axi_arvalid && s_axi_arready;
	assign rd_addr_q = {s_axi_araddr[7:2], 2'b00};
	assign rd_status = {25'h000_0000, dir_sync_ff[1], mirror_cfg_ff, !sensor_rst_n_ff,
		state_ff};
	assign rd_hit    = (rd_addr_q == REG_CTRL) || (rd_addr_q == REG_STATUS)
		|| (rd_addr_q == REG_EXPOSURE) || (rd_addr_q == REG_FRAME_CNT);
	assign rd_data   = (rd_addr_q == REG_STATUS)    ? rd_status :
		(rd_addr_q == REG_EXPOSURE)  ? {16'h0000, exposure_ff} :
		(rd_addr_q == REG_FRAME_CNT) ? frame_cnt_ff : 32'h0000_0000;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Circuit reset: button or software, holds the sensor path in reset
	assign circ_rst  = key_press.circuit_reset || sw_reset;
	assign srst_done = srst_cnt_ff == 8'(SENSOR_RST_CYCLES);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			srst_cnt_ff     <= 8'h00;
			sensor_rst_n_ff <= 1'b0;
			mirror_cfg_ff   <= MIRROR_RST;
		end else begin
			srst_cnt_ff     <= circ_rst ? 8'h00 : (srst_done ? srst_cnt_ff : srst_cnt_ff + 8'h01);
			sensor_rst_n_ff <= srst_done && !circ_rst;
			// Switch is only sampled while the sensor is held in reset
			if (!srst_done) begin
				mirror_cfg_ff <= !mir_sync_ff[1];
			end
		end
	end

	// Viewer mode
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_WAIT_CFG: begin
				if (sensor_rst_n_ff && config_done) begin
					nxt_state = ST_LIVE;
				end
			end
			ST_LIVE: begin
				if (key_press.capture || sw_capture) begin
					nxt_state = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				// Enter ST_STILL on a frame boundary so the held picture is whole
				if (key_press.live || sw_live) begin
					nxt_state = ST_LIVE;
				end else if (frame_edge) begin
					nxt_state = ST_STILL;
				end
			end
			ST_STILL: begin
				if (key_press.live || sw_live) begin
					nxt_state = ST_LIVE;
				end
			end
			default: nxt_state = ST_WAIT_CFG;
		endcase
		if (circ_rst) begin
			nxt_state = ST_WAIT_CFG;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff  <= ST_WAIT_CFG;
			freeze_ff <= 1'b1;
		end else begin
			state_ff  <= nxt_state;
			freeze_ff <= nxt_state != ST_LIVE;
		end
	end

	// Exposure: step grows each tick the button stays held, up to EXP_STEP_MAX
	assign tick         = key_held.exposure && (tick_cnt_ff == 24'(TICK_CYCLES - 1));
	assign exp_up_sat   = (EXPOSURE_MAX - exposure_ff) < step_ff;
	assign exp_dn_sat   = (exposure_ff - EXPOSURE_MIN) < step_ff;
	assign nxt_exposure = dir_sync_ff[1]
		? (exp_dn_sat ? EXPOSURE_MIN : exposure_ff - step_ff)
		: (exp_up_sat ? EXPOSURE_MAX : exposure_ff + step_ff);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt_ff <= 24'h00_0000;
			step_ff     <= EXP_STEP_RST;
			exposure_ff <= EXPOSURE_RST;
		end else if (circ_rst) begin
			tick_cnt_ff <= 24'h00_0000;
			step_ff     <= EXP_STEP_RST;
			exposure_ff <= EXPOSURE_RST;
		end else begin
			tick_cnt_ff <= (key_held.exposure && !tick) ? tick_cnt_ff + 24'h00_0001 : 24'h00_0000;
			if (!key_held.exposure) begin
				step_ff <= EXP_STEP_RST;
			end else if (tick && step_ff != EXP_STEP_MAX) begin
				step_ff <= step_ff + 16'h0001;
			end
			// Button wins over a software write in the same cycle
			if (tick) begin
				exposure_ff <= nxt_exposure;
			end else if (wr_exp) begin
				if (s_axi_wstrb[0]) exposure_ff[7:0] <= s_axi_wdata[7:0];
				if (s_axi_wstrb[1]) exposure_ff[15:8] <= s_axi_wdata[15:8];
			end
		end
	end

	// Frame counter and display, no effect on control
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_cnt_ff <= FRAME_CNT_RST;
		end else if (circ_rst) begin
			frame_cnt_ff <= FRAME_CNT_RST;
		end else if (frame_edge) begin
			frame_cnt_ff <= frame_cnt_ff + 32'h0000_0001;
		end
	end

	genvar gd;
	generate
		for (gd = 0; gd < 8; gd++) begin : g_digit
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					hex_seg_n_ff[gd] <= 7'h7F;
				end else begin
					hex_seg_n_ff[gd] <= camctl_seg(frame_cnt_ff[4*gd +: 4]);
				end
			end
		end
	endgenerate

endmodule : camctl_top

// ---- bench/camctl_asserts.sv ----
// Port-level checks of the camera viewer control block
`timescale 1ns/1ps
module camctl_asserts #(
	parameter int DEB_CYCLES  = 4,
	parameter int TICK_CYCLES = 8
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// Switch and sensor side
	input wire logic        exposure_direction_switch,
	input wire logic        sensor_rst_n_ff,
	input wire logic        mirror_cfg_ff,
	input wire logic [15:0] exposure_ff,
	input wire logic        freeze_ff,
	// Register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_srst_len: assert property ($fell(sensor_rst_n_ff) |-> !sensor_rst_n_ff [*8])
		else $error("sensor reset pulse too short");
	a_srst_freeze: assert property (!sensor_rst_n_ff |-> freeze_ff)
		else $error("display live during sensor reset");
	a_mirror_hold: assert property (sensor_rst_n_ff && $past(sensor_rst_n_ff) |-> $stable(mirror_cfg_ff))
		else $error("mirror setting changed outside reset");
	a_exp_nonzero: assert property (exposure_ff != 16'h0000)
		else $error("exposure reached zero");
	a_exp_dir: assert property ($changed(exposure_ff) && !$past(s_axi_wvalid) && sensor_rst_n_ff
		&& $past(sensor_rst_n_ff) |-> (exposure_direction_switch ?
		exposure_ff < $past(exposure_ff) : exposure_ff > $past(exposure_ff)))
		else $error("exposure moved the wrong way");
	a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
		else $error("write address taken without data");
	a_b_follows: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	a_r_follows: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");

	c_freeze: cover property (sensor_rst_n_ff && $rose(freeze_ff));
	c_resume: cover property ($fell(freeze_ff));
	c_exp_move: cover property (sensor_rst_n_ff && $changed(exposure_ff));
endmodule : camctl_asserts

bind camctl_top camctl_asserts #(.DEB_CYCLES(DEB_CYCLES), .TICK_CYCLES(TICK_CYCLES)) u_camctl_asserts (.*);

// ---- bench/camctl_sensor_model.sv ----
// Sensor side model: configuration done flag and frame pulses
`timescale 1ns/1ps
module camctl_sensor_model #(
	parameter int CFG_DLY = 12
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// From block and bench
	input  wire logic sensor_rst_n_ff,
	input  wire logic fire,
	// To block
	output logic      config_done,
	output logic      frame_start
);
	int cfg_cnt_ff;
	int pulse_ff;

	// Configuration restarts whenever the sensor is held in reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_cnt_ff  <= 0;
			config_done <= 1'b0;
			pulse_ff    <= 0;
			frame_start <= 1'b0;
		end else begin
			cfg_cnt_ff  <= !sensor_rst_n_ff ? 0 : (cfg_cnt_ff < CFG_DLY ? cfg_cnt_ff + 1 : cfg_cnt_ff);
			config_done <= sensor_rst_n_ff && cfg_cnt_ff == CFG_DLY;
			pulse_ff    <= fire ? 3 : (pulse_ff > 0 ? pulse_ff - 1 : 0);
			frame_start <= fire || pulse_ff > 1;
		end
	end
endmodule : camctl_sensor_model

// ---- bench/tb.sv ----
// Self-checking bench of the camera viewer control block
`timescale 1ns/1ps
module tb;
	import camctl_pkg::*;
	localparam int DEB = 4;
	localparam int TCK = 8;
	logic              clk, nrst, exposure_direction_switch, line_mirror_switch, fire;
	logic              frame_start, config_done, sensor_rst_n_ff, mirror_cfg_ff, freeze_ff;
	logic [3:0]        key_n, s_axi_wstrb;
	logic [15:0]       exposure_ff;
	logic [7:0][6:0]   hex_seg_n_ff;
	logic [7:0]        s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata, rs, rv;
	logic [1:0]        s_axi_bresp, s_axi_rresp, rr;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int                bad_count, checks, frames, ex;
	logic [6:0]        seg [16] = '{7'h40, 7'h79, 7'h24, 7'h30, 7'h19, 7'h12, 7'h02, 7'h78,
		7'h00, 7'h10, 7'h08, 7'h03, 7'h46, 7'h21, 7'h06, 7'h0E};

	camctl_top #(.DEB_CYCLES(DEB), .TICK_CYCLES(TCK)) u_camctl_top (.*);
	camctl_sensor_model u_camctl_sensor_model (.*);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xorshift();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xorshift

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rr = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	// Late rready exercises the hold of read data
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge clk);
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic press(input int k, input int h);
		@(posedge clk);
		key_n[k] <= 1'b0;
		repeat (h) @(posedge clk);
		key_n[k] <= 1'b1;
		repeat (DEB + 6) @(posedge clk);
	endtask : press

	task automatic frame();
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (10) @(posedge clk);
		frames++;
	endtask : frame

	// Held button gives 1+2+3+... per tick, so the result is a triangular offset
	task automatic chk_exp(input int b, input int sgn);
		int e;
		int v;
		e = -1;
		for (int n = 4; n < 40; n++) begin
			v = b + sgn * n * (n + 1) / 2;
			v = v < 1 ? 1 : (v > 65535 ? 65535 : v);
			if (v == exposure_ff) e = v;
		end
		chk(exposure_ff, e);
		ex = e;
	endtask : chk_exp

	task automatic st(input logic [3:0] e);
		rd(REG_STATUS);
		chk(rv[3:0], e);
	endtask : st

	task automatic end_sim();
		$display("counts: %0d checks, %0d mismatches", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_sim();
	end

	initial begin
		{nrst, exposure_direction_switch, line_mirror_switch, fire} = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
		s_axi_wstrb = 4'hF;
		key_n = 4'hF;
		rs = 32'h0000_439B;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk(sensor_rst_n_ff, 1'b0);
		chk(mirror_cfg_ff, 1'b1);
		chk(exposure_ff, EXPOSURE_RST);
		repeat (130) @(posedge clk);
		st(4'h2);
		chk(rv[6:4], 3'h2);
		chk(freeze_ff, 1'b0);
		rd(REG_CTRL);
		chk(rv, 32'h0000_0000);
		rd(8'h10);
		chk(rr, RESP_SLVERR);
		wr(REG_STATUS, 32'h0000_0001);
		chk(rr, RESP_SLVERR);
		$display("test startup done");
		repeat (xorshift() % 4 + 2) frame();
		rd(REG_FRAME_CNT);
		chk(rv, frames);
		chk(hex_seg_n_ff[0], seg[frames % 16]);
		chk(hex_seg_n_ff[1], seg[frames / 16 % 16]);
		$display("test frames done");
		press(2, DEB + 4);
		chk(freeze_ff, 1'b1);
		frame();
		st(4'h8);
		press(2, DEB + 4);
		st(4'h8);
		press(3, DEB + 4);
		chk(freeze_ff, 1'b0);
		st(4'h2);
		wr(REG_CTRL, 32'h0000_0001);
		st(4'h4);
		frame();
		wr(REG_CTRL, 32'h0000_0002);
		st(4'h2);
		// Live request before the freezing frame edge arrives
		wr(REG_CTRL, 32'h0000_0001);
		st(4'h4);
		wr(REG_CTRL, 32'h0000_0002);
		st(4'h2);
		chk(freeze_ff, 1'b0);
		$display("test modes done");
		ex = 32'h1000 + xorshift() % 32'h4000;
		wr(REG_EXPOSURE, ex);
		chk(rr, RESP_OKAY);
		press(1, 70);
		chk_exp(ex, 1);
		press(1, 70);
		chk_exp(ex, 1);
		exposure_direction_switch <= 1'b1;
		press(1, 70);
		chk_exp(ex, -1);
		wr(REG_EXPOSURE, 32'h0000_0003);
		press(1, 70);
		chk_exp(3, -1);
		// Low lane only: upper byte of exposure must survive
		s_axi_wstrb <= 4'h1;
		wr(REG_EXPOSURE, 32'h0000_AB05);
		s_axi_wstrb <= 4'hF;
		chk(rr, RESP_OKAY);
		rd(REG_EXPOSURE);
		chk(rv, {16'h0000, ex[15:8], 8'h05});
		$display("test exposure done");
		line_mirror_switch <= 1'b1;
		repeat (10) @(posedge clk);
		chk(mirror_cfg_ff, 1'b1);
		press(0, DEB + 4);
		repeat (130) @(posedge clk);
		chk(mirror_cfg_ff, 1'b0);
		chk(exposure_ff, EXPOSURE_RST);
		st(4'h2);
		rd(REG_FRAME_CNT);
		chk(rv, 32'h0000_0000);
		line_mirror_switch <= 1'b0;
		wr(REG_CTRL, 32'h0000_0004);
		repeat (130) @(posedge clk);
		chk(mirror_cfg_ff, 1'b1);
		$display("test mirror done");
		end_sim();
	end
endmodule : tb
